// [common/lhg_pkg.sv]
// Shared constants for the low-g / high-g acceleration event block.
// Assumes a single 40 MHz clock and byte-wide configuration registers.
`default_nettype none
package lhg_pkg;
    // Register byte addresses
    localparam logic [7:0] LHG_ADDR_SRC_A = 8'h58;
    localparam logic [7:0] LHG_ADDR_SRC_B = 8'h59;
    localparam logic [7:0] LHG_ADDR_LOW_DUR = 8'h5a;
    localparam logic [7:0] LHG_ADDR_LOW_TH = 8'h5b;
    localparam logic [7:0] LHG_ADDR_HYS_MODE = 8'h5c;
    localparam logic [7:0] LHG_ADDR_HIGH_DUR = 8'h5d;
    localparam logic [7:0] LHG_ADDR_HIGH_TH = 8'h5e;

    // Reset values
    localparam logic [7:0] LHG_RST_SRC_A = 8'h00;
    localparam logic [7:0] LHG_RST_SRC_B = 8'h00;
    localparam logic [7:0] LHG_RST_LOW_DUR = 8'h07;
    localparam logic [7:0] LHG_RST_LOW_TH = 8'h30;
    localparam logic [7:0] LHG_RST_HYS_MODE = 8'h81;
    localparam logic [7:0] LHG_RST_HIGH_DUR = 8'h0b;
    localparam logic [7:0] LHG_RST_HIGH_TH = 8'hc0;

    // Implemented bits; reserved bits are not stored and read as zero
    localparam logic [7:0] LHG_MASK_SRC_A = 8'h88;
    localparam logic [7:0] LHG_MASK_SRC_B = 8'h80;
    localparam logic [7:0] LHG_MASK_HYS_MODE = 8'hc7;

    // Field positions
    localparam int LHG_BIT_LH_SRC = 7;
    localparam int LHG_BIT_TAP_SRC = 3;
    localparam int LHG_BIT_MOT_SRC = 7;
    localparam int LHG_BIT_LOW_MODE = 2;
    localparam int LHG_LSB_LOW_HY = 0;
    localparam int LHG_LSB_HIGH_HY = 6;

    // Sample layout: three signed axes, X in the top lane
    localparam int LHG_AXW = 16;
    localparam int LHG_VECW = 3 * LHG_AXW;
    // Magnitude width in fine units (one 2 g range LSB, about 0.061 mg)
    localparam int LHG_FW = 22;
    // Threshold zero value is 64 fine units, one step is 128 (2^7)
    localparam logic [LHG_FW-1:0] LHG_TH_ZERO_FINE = 22'h000040;
    localparam int LHG_TH_STEP_SHIFT = 7;
    // One hysteresis step, 125 mg, is 2048 fine units (2^11)
    localparam int LHG_HY_STEP_SHIFT = 11;

    // Delay tick: 2.5 ms at 40 MHz
    localparam int LHG_CLK_KHZ = 40000;
    localparam int LHG_TICK_US = 2500;
    localparam int LHG_TICK_CYC = LHG_TICK_US * LHG_CLK_KHZ / 1000;

    // Persistence tracker states
    typedef enum logic [2:0] {
        LHG_ST_IDLE = 3'b001,
        LHG_ST_WAIT = 3'b010,
        LHG_ST_FIRE = 3'b100
    } lhg_state_e;
endpackage
`default_nettype wire

// [hw/lhg_persist.sv]
// Persistence tracker: raises an event after a condition has held long enough.
// Assumes set and release are never true together and tick is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module lhg_persist
    import lhg_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // Timing and configuration
    input wire logic tick_i,
    input wire logic [7:0] dur_i,
    // Condition inputs
    input wire logic set_i,
    input wire logic release_i,
    // Event output
    output logic irq_o
);
    lhg_state_e state_q, state_d; // Tracker state
    logic [7:0] cnt_q, cnt_d; // Ticks seen while condition holds
    logic irq_q, irq_d; // Event level

    // Next-state logic for the tracker
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        irq_d = irq_q;
        case (state_q)
            LHG_ST_IDLE: begin
                // Condition entered: start counting from zero
                if (set_i) begin
                    state_d = LHG_ST_WAIT;
                    cnt_d = 8'h00;
                end
            end
            LHG_ST_WAIT: begin
                // Falling back past hysteresis restarts the delay
                if (release_i) begin
                    state_d = LHG_ST_IDLE;
                end else if (tick_i) begin
                    // Fire on the (delay + 1)th tick
                    if (cnt_q == dur_i) begin
                        state_d = LHG_ST_FIRE;
                        irq_d = 1'b1;
                    end else begin
                        cnt_d = cnt_q + 8'h01;
                    end
                end
            end
            LHG_ST_FIRE: begin
                // Event holds until the condition is released
                if (release_i) begin
                    state_d = LHG_ST_IDLE;
                    irq_d = 1'b0;
                end
            end
            default: begin
                state_d = LHG_ST_IDLE;
                cnt_d = 8'h00;
                irq_d = 1'b0;
            end
        endcase
    end

    // State registers
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= LHG_ST_IDLE;
            cnt_q <= 8'h00;
            irq_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            irq_q <= irq_d;
        end
    end

    assign irq_o = irq_q;

    // Event rises only on a tick that completes the delay count
    AST_DELAY_DONE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        $rose(irq_o) |-> $past(tick_i && cnt_q == dur_i && !release_i))
        else $error("event rose without a completed delay");
    // Release drops an active event on the next edge
    AST_RELEASE_DROP: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        irq_o && release_i |=> !irq_o && state_q == LHG_ST_IDLE)
        else $error("event survived a release");
endmodule
`default_nettype wire

// [hw/lhg_core.sv]
// Low-g / high-g detection with data source selection and its registers.
// Assumes a synchronous byte register port driven by the serial host
// interface, and acceleration samples synchronous to mclk_i.
//
// What this block does
// - Source bit 7 picks low/high-g data
// - Source bit 3 picks tap data
// - Second source bit 7 picks motion data
// - Two source registers reset to zero
// - Five consecutive low/high-g configuration bytes
// - Low-g fires after (delay+1) x 2.5 ms
// - Low threshold value x 7.81 mg, zero 3.91
// - Low defaults 20 ms and 375 mg
// - High hysteresis scales with range
// - Low mode: per-axis or axis sum
// - Low hysteresis value x 125 mg
// - High-g fires after (delay+1) x 2.5 ms
// - High threshold scales with range
// - High threshold zero gives half step
// - Pre-filtered high-g blocks low power
`timescale 1ns/1ps
`default_nettype none
module lhg_core
    import lhg_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = LHG_TICK_CYC // Clocks per 2.5 ms tick
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Acceleration samples, X in [47:32]
    input wire logic [LHG_VECW-1:0] filt_accel_i,
    input wire logic [LHG_VECW-1:0] pref_accel_i,
    input wire logic [1:0] range_i,
    // Power management
    input wire logic low_power_req_i,
    output logic low_power_en_o,
    // Data to the tap and motion engines
    output logic [LHG_VECW-1:0] tap_accel_o,
    output logic [LHG_VECW-1:0] mot_accel_o,
    // Events
    output logic low_g_irq_o,
    output logic high_g_irq_o
);
    if (TICK_CYCLES < 2) begin : g_tick_chk
        $error("TICK_CYCLES must be at least 2");
    end

    // Magnitude of one axis in fine units for the given range
    function automatic logic [LHG_FW-1:0] lhg_fine(input logic [LHG_AXW-1:0] a,
                                                   input logic [1:0] r);
        logic [LHG_AXW-1:0] mag;
        mag = a[LHG_AXW-1] ? (~a + 16'h0001) : a;
        return LHG_FW'({6'h00, mag}) << r;
    endfunction

    // Threshold in fine units at 2 g scale
    function automatic logic [LHG_FW-1:0] lhg_th(input logic [7:0] th);
        return (th == 8'h00) ? LHG_TH_ZERO_FINE :
               (LHG_FW'({14'h0000, th}) << LHG_TH_STEP_SHIFT);
    endfunction

    // Hysteresis in fine units at 2 g scale
    function automatic logic [LHG_FW-1:0] lhg_hy(input logic [1:0] hy);
        return LHG_FW'({20'h00000, hy}) << LHG_HY_STEP_SHIFT;
    endfunction

    // Configuration registers
    logic [7:0] src_a_q, src_a_d; // Low/high-g and tap source
    logic [7:0] src_b_q, src_b_d; // Motion source
    logic [7:0] low_dur_q, low_dur_d; // Low-g delay
    logic [7:0] low_th_q, low_th_d; // freefall_threshold
    logic [7:0] hys_q, hys_d; // Hysteresis and low-g mode
    logic [7:0] high_dur_q, high_dur_d; // High-g delay
    logic [7:0] high_th_q, high_th_d; // shock_threshold
    logic [7:0] rdata_q, rdata_d; // Registered read data

    // Register writes and reads
    always_comb begin
        src_a_d = src_a_q;
        src_b_d = src_b_q;
        low_dur_d = low_dur_q;
        low_th_d = low_th_q;
        hys_d = hys_q;
        high_dur_d = high_dur_q;
        high_th_d = high_th_q;
        rdata_d = rdata_q;
        // Consecutive byte map starting at the two bases
        if (reg_wr_i) begin
            case (reg_addr_i)
                LHG_ADDR_SRC_A: src_a_d = reg_wdata_i & LHG_MASK_SRC_A;
                LHG_ADDR_SRC_B: src_b_d = reg_wdata_i & LHG_MASK_SRC_B;
                LHG_ADDR_LOW_DUR: low_dur_d = reg_wdata_i;
                LHG_ADDR_LOW_TH: low_th_d = reg_wdata_i;
                LHG_ADDR_HYS_MODE: hys_d = reg_wdata_i & LHG_MASK_HYS_MODE;
                LHG_ADDR_HIGH_DUR: high_dur_d = reg_wdata_i;
                LHG_ADDR_HIGH_TH: high_th_d = reg_wdata_i;
                default: begin
                    // Unmapped addresses ignore writes
                end
            endcase
        end
        // Reads return stored bits; unmapped addresses read zero
        if (reg_rd_i) begin
            case (reg_addr_i)
                LHG_ADDR_SRC_A: rdata_d = src_a_q;
                LHG_ADDR_SRC_B: rdata_d = src_b_q;
                LHG_ADDR_LOW_DUR: rdata_d = low_dur_q;
                LHG_ADDR_LOW_TH: rdata_d = low_th_q;
                LHG_ADDR_HYS_MODE: rdata_d = hys_q;
                LHG_ADDR_HIGH_DUR: rdata_d = high_dur_q;
                LHG_ADDR_HIGH_TH: rdata_d = high_th_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // Register storage with documented reset values
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            src_a_q <= LHG_RST_SRC_A;
            src_b_q <= LHG_RST_SRC_B;
            low_dur_q <= LHG_RST_LOW_DUR;
            low_th_q <= LHG_RST_LOW_TH;
            hys_q <= LHG_RST_HYS_MODE;
            high_dur_q <= LHG_RST_HIGH_DUR;
            high_th_q <= LHG_RST_HIGH_TH;
            rdata_q <= 8'h00;
        end else begin
            src_a_q <= src_a_d;
            src_b_q <= src_b_d;
            low_dur_q <= low_dur_d;
            low_th_q <= low_th_d;
            hys_q <= hys_d;
            high_dur_q <= high_dur_d;
            high_th_q <= high_th_d;
            rdata_q <= rdata_d;
        end
    end

    // Source selection and power gating
    logic [LHG_VECW-1:0] lh_accel_q, lh_accel_d; // Data seen by low/high-g
    logic [LHG_VECW-1:0] tap_q, tap_d; // Data for tap engines
    logic [LHG_VECW-1:0] mot_q, mot_d; // Data for motion engines
    logic lp_q, lp_d; // Low power granted

    // Per-group multiplexers between filtered and pre-filtered data
    always_comb begin
        lh_accel_d = src_a_q[LHG_BIT_LH_SRC] ? pref_accel_i : filt_accel_i;
        tap_d = src_a_q[LHG_BIT_TAP_SRC] ? pref_accel_i : filt_accel_i;
        mot_d = src_b_q[LHG_BIT_MOT_SRC] ? pref_accel_i : filt_accel_i;
        // Pre-filtered low/high-g data keeps the sensor awake
        lp_d = low_power_req_i && !src_a_q[LHG_BIT_LH_SRC];
    end

    // Selected data and power grant registers
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lh_accel_q <= '0;
            tap_q <= '0;
            mot_q <= '0;
            lp_q <= 1'b0;
        end else begin
            lh_accel_q <= lh_accel_d;
            tap_q <= tap_d;
            mot_q <= mot_d;
            lp_q <= lp_d;
        end
    end

    // Tick divider
    logic [31:0] div_q, div_d; // Cycle counter inside a tick
    logic tick_q, tick_d; // One-cycle tick pulse

    // Divide the clock down to the 2.5 ms delay step
    always_comb begin
        tick_d = (div_q == TICK_CYCLES - 1);
        div_d = tick_d ? 32'h00000000 : div_q + 32'h00000001;
    end

    // Divider registers
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_q <= 32'h00000000;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_d;
            tick_q <= tick_d;
        end
    end

    // Threshold evaluation
    logic [LHG_FW-1:0] fx, fy, fz, fsum; // Axis magnitudes and their sum
    logic [LHG_FW-1:0] low_th_f, low_rel_f; // Low set and release levels
    logic [LHG_FW-1:0] high_th_f, high_hy_f, high_rel_f; // High levels
    logic low_set, low_rel, high_set, high_rel; // Condition edges

    // Compare magnitudes with thresholds and hysteresis bands
    always_comb begin
        fx = lhg_fine(lh_accel_q[3*LHG_AXW-1:2*LHG_AXW], range_i);
        fy = lhg_fine(lh_accel_q[2*LHG_AXW-1:LHG_AXW], range_i);
        fz = lhg_fine(lh_accel_q[LHG_AXW-1:0], range_i);
        fsum = fx + fy + fz;
        // Low-g levels do not depend on range
        low_th_f = lhg_th(low_th_q);
        low_rel_f = low_th_f + lhg_hy(hys_q[LHG_LSB_LOW_HY +: 2]);
        // High-g levels double with each range step
        high_th_f = lhg_th(high_th_q) << range_i;
        high_hy_f = lhg_hy(hys_q[LHG_LSB_HIGH_HY +: 2]) << range_i;
        high_rel_f = (high_hy_f > high_th_f) ? '0 : high_th_f - high_hy_f;
        // Axis sum or per-axis low-g
        if (hys_q[LHG_BIT_LOW_MODE]) begin
            low_set = fsum < low_th_f;
            low_rel = fsum > low_rel_f;
        end else begin
            low_set = (fx < low_th_f) && (fy < low_th_f) && (fz < low_th_f);
            low_rel = (fx > low_rel_f) || (fy > low_rel_f) || (fz > low_rel_f);
        end
        // Any axis above threshold sets, all below the band releases
        high_set = (fx > high_th_f) || (fy > high_th_f) || (fz > high_th_f);
        high_rel = (fx <= high_rel_f) && (fy <= high_rel_f) && (fz <= high_rel_f)
                   && !high_set;
    end

    // Low-g persistence tracker
    lhg_persist u_low (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .tick_i(tick_q),
        .dur_i(low_dur_q),
        .set_i(low_set),
        .release_i(low_rel),
        .irq_o(low_g_irq_o)
    );

    // High-g persistence tracker
    lhg_persist u_high (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .tick_i(tick_q),
        .dur_i(high_dur_q),
        .set_i(high_set),
        .release_i(high_rel),
        .irq_o(high_g_irq_o)
    );

    assign reg_rdata_o = rdata_q;
    assign low_power_en_o = lp_q;
    assign tap_accel_o = tap_q;
    assign mot_accel_o = mot_q;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    AST_LH_SOURCE: assert property (
        1 |=> lh_accel_q == $past(src_a_q[LHG_BIT_LH_SRC] ? pref_accel_i : filt_accel_i))
        else $error("low/high-g data source wrong");
    AST_TAP_SOURCE: assert property (
        src_a_q[LHG_BIT_TAP_SRC] && $stable(src_a_q) |=> tap_accel_o == $past(pref_accel_i))
        else $error("tap data not pre-filtered when selected");
    AST_MOT_SOURCE: assert property (
        !src_b_q[LHG_BIT_MOT_SRC] && $stable(src_b_q) |=> mot_accel_o == $past(filt_accel_i))
        else $error("motion data not filtered when selected");
    AST_RESET_SRC: assert property (
        $rose(rstn_i) |-> src_a_q == 8'h00 && src_b_q == 8'h00)
        else $error("source registers not zero after reset");
    AST_RESET_LOW: assert property (
        $rose(rstn_i) |-> low_dur_q == 8'h07 && low_th_q == 8'h30)
        else $error("low-g defaults wrong after reset");
    AST_RESET_HIGH: assert property (
        $rose(rstn_i) |-> high_dur_q == 8'h0b)
        else $error("high-g delay default wrong after reset");
    // Write, one quiet edge, then a read of the same byte returns the written value
    AST_WRITE_READ: assert property (
        (reg_wr_i && reg_addr_i == LHG_ADDR_HIGH_TH) ##1 !reg_wr_i
        ##1 (reg_rd_i && !reg_wr_i && reg_addr_i == LHG_ADDR_HIGH_TH)
        |=> reg_rdata_o == $past(reg_wdata_i, 3))
        else $error("high threshold read-back mismatch");
    AST_LP_BLOCK: assert property (
        src_a_q[LHG_BIT_LH_SRC] |=> !low_power_en_o)
        else $error("low power granted with pre-filtered high-g data");

    COV_LOW_FIRE: cover property ($rose(low_g_irq_o));
    COV_HIGH_FIRE: cover property ($rose(high_g_irq_o));
    COV_PREF_HIGH: cover property (src_a_q[LHG_BIT_LH_SRC] && high_g_irq_o);
    COV_SUM_MODE: cover property (hys_q[LHG_BIT_LOW_MODE] && $rose(low_g_irq_o));
endmodule
`default_nettype wire

// [test/lhg_host_model.sv]
// Host-side model of the byte register port that stands for the serial link.
// Assumes the bench calls its tasks and the device samples on mclk_i rising.
`timescale 1ns/1ps
`default_nettype none
module lhg_host_model (
    // Clock
    input wire logic mclk_i,
    // Register port towards the device
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_rd_o,
    input wire logic [7:0] reg_rdata_i
);
    // Quiet port before the first access
    initial begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o = 1'b0;
    end

    // Released lines show the inverse of the last value, never a stale copy
    task automatic idle();
        reg_addr_o = ~reg_addr_o;
        reg_wdata_o = ~reg_wdata_o;
    endtask

    // One write, strobe held up to the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        #1;
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(posedge mclk_i);
        #1;
        reg_wr_o = 1'b0;
        idle();
    endtask

    // One read, data taken once the edge after the strobe has landed
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        #1;
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(posedge mclk_i);
        #1;
        d = reg_rdata_i;
        reg_rd_o = 1'b0;
        idle();
    endtask
endmodule
`default_nettype wire

// [test/tb_lhg_core.sv]
// Self-checking bench for the low-g / high-g event block.
// Assumes the host model on the register port and a shortened delay tick.
`timescale 1ns/1ps
`default_nettype none
module tb_lhg_core;
    import lhg_pkg::*;
    localparam int TC = 4; // Clocks per delay tick in this run
    // Reset values and implemented bits for addresses 57..5f
    localparam logic [7:0] RST_T [9] = '{8'h00, LHG_RST_SRC_A, LHG_RST_SRC_B, LHG_RST_LOW_DUR,
        LHG_RST_LOW_TH, LHG_RST_HYS_MODE, LHG_RST_HIGH_DUR, LHG_RST_HIGH_TH, 8'h00};
    localparam logic [7:0] MSK_T [9] = '{8'h00, LHG_MASK_SRC_A, LHG_MASK_SRC_B, 8'hff,
        8'hff, LHG_MASK_HYS_MODE, 8'hff, 8'hff, 8'h00};
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
    logic reg_wr, reg_rd;
    logic [LHG_VECW-1:0] filt = '0;
    logic [LHG_VECW-1:0] pref = '0;
    logic [LHG_VECW-1:0] tap_v, mot_v;
    logic [1:0] range = 2'h0;
    logic lp_req = 1'b0;
    logic lp_en, low_irq, high_irq;
    int failures = 0;
    int compares = 0;

    // Free-running 40 MHz clock
    always #12.5 mclk_i = ~mclk_i;

    lhg_host_model host (.mclk_i(mclk_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
        .reg_wdata_o(reg_wdata), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata));

    lhg_core #(.TICK_CYCLES(TC)) dut (.mclk_i(mclk_i), .rstn_i(rstn_i),
        .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata),
        .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .filt_accel_i(filt),
        .pref_accel_i(pref), .range_i(range), .low_power_req_i(lp_req),
        .low_power_en_o(lp_en), .tap_accel_o(tap_v), .mot_accel_o(mot_v),
        .low_g_irq_o(low_irq), .high_g_irq_o(high_irq));

    // Verdict and end of run
    task automatic finish_test();
        if (failures == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Compare a register byte
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Compare a sample vector
    task automatic chk_vec(input logic [LHG_VECW-1:0] got, input logic [LHG_VECW-1:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Compare a single flag
    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Drive both sample inputs just after an edge
    task automatic samp(input logic [LHG_VECW-1:0] f, input logic [LHG_VECW-1:0] p);
        @(posedge mclk_i);
        #1;
        filt = f;
        pref = p;
    endtask

    // Wait a bounded time for an event and check whether and when it came
    task automatic expect_irq(input logic hi, input logic exp, input int dur);
        int n;
        logic v;
        n = 0;
        v = hi ? high_irq : low_irq;
        while (v !== 1'b1 && n < (dur + 1) * TC + 4) begin
            @(posedge mclk_i);
            #1;
            n++;
            v = hi ? high_irq : low_irq;
        end
        chk_bit(v, exp);
        if (exp) begin
            // Sample register and set take two edges, so the first tick counts on the third
            chk_bit(n >= dur * TC + 3, 1'b1);
            if (v !== 1'b1) begin
                finish_test();
            end
        end
    endtask

    // Release the event, then hold a sample on X, Y and Z and check the outcome
    task automatic trial(input logic hi, input logic [15:0] x, input logic [15:0] y,
        input logic [15:0] z, input logic exp, input int dur);
        samp(hi ? '0 : {16'h4000, 32'h0}, '0);
        repeat (4) @(posedge mclk_i);
        #1;
        chk_bit(hi ? high_irq : low_irq, 1'b0);
        samp({x, y, z}, '0);
        expect_irq(hi, exp, dur);
    endtask

    // After firing: a value inside the band keeps it, one past the band drops it
    task automatic band(input logic hi, input logic [15:0] keep, input logic [15:0] drop);
        samp({keep, 32'h0}, '0);
        repeat (6) @(posedge mclk_i);
        #1;
        chk_bit(hi ? high_irq : low_irq, 1'b1);
        samp({drop, 32'h0}, '0);
        repeat (3) @(posedge mclk_i);
        #1;
        chk_bit(hi ? high_irq : low_irq, 1'b0);
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge mclk_i);
        #1;
        rstn_i = 1'b1;
        // Reset values, unmapped neighbours read zero
        for (int i = 0; i < 9; i++) begin
            host.rd(8'h57 + 8'(i), rd_val);
            chk_reg(rd_val, RST_T[i]);
        end
        // Default delays fire in their windows
        trial(1'b0, 16'h0, 16'h0, 16'h0, 1'b1, 7);
        trial(1'b1, 16'h7000, 16'h0, 16'h0, 1'b1, 11);
        // Reserved bits and unmapped places are not stored
        for (int i = 0; i < 9; i++) begin
            host.wr(8'h57 + 8'(i), 8'hff);
            host.rd(8'h57 + 8'(i), rd_val);
            chk_reg(rd_val, MSK_T[i]);
            host.wr(8'h57 + 8'(i), RST_T[i]);
        end
        // Data source for tap, motion and power gating
        for (int s = 0; s < 2; s++) begin
            host.wr(LHG_ADDR_SRC_A, {s[0], 3'h0, s[0], 3'h0});
            host.wr(LHG_ADDR_SRC_B, {s[0], 7'h0});
            samp({16'h1234, 16'h5678, 16'h9abc}, {16'h0fed, 16'hcba9, 16'h8765});
            lp_req = 1'b1;
            repeat (2) @(posedge mclk_i);
            #1;
            chk_vec(tap_v, s ? pref : filt);
            chk_vec(mot_v, s ? pref : filt);
            chk_bit(lp_en, s == 0);
            // Host drops the low power request after each source setting
            lp_req = 1'b0;
        end
        // Low-g follows the selected source
        samp({16'h4000, 32'h0}, '0);
        expect_irq(1'b0, 1'b1, 7);
        host.wr(LHG_ADDR_SRC_A, 8'h00);
        repeat (3) @(posedge mclk_i);
        #1;
        chk_bit(low_irq, 1'b0);
        host.wr(LHG_ADDR_SRC_B, 8'h00);
        // Low-g delay at both ends of a short count
        host.wr(LHG_ADDR_LOW_DUR, 8'h00);
        trial(1'b0, 16'h0, 16'h0, 16'h0, 1'b1, 0);
        host.wr(LHG_ADDR_LOW_DUR, 8'h03);
        trial(1'b0, 16'h0, 16'h0, 16'h0, 1'b1, 3);
        // Low threshold boundaries, zero field and range independence
        host.wr(LHG_ADDR_LOW_TH, 8'h00);
        trial(1'b0, 16'd63, 16'h0, 16'h0, 1'b1, 3);
        trial(1'b0, 16'd64, 16'h0, 16'h0, 1'b0, 3);
        host.wr(LHG_ADDR_LOW_TH, 8'h01);
        range = 2'h1;
        trial(1'b0, 16'd63, 16'h0, 16'h0, 1'b1, 3);
        trial(1'b0, 16'd64, 16'h0, 16'h0, 1'b0, 3);
        range = 2'h0;
        trial(1'b0, 16'd127, 16'hff81, 16'h0, 1'b1, 3);
        trial(1'b0, 16'd128, 16'h0, 16'h0, 1'b0, 3);
        // Low hysteresis bands of one and two steps
        for (int h = 1; h < 3; h++) begin
            host.wr(LHG_ADDR_HYS_MODE, 8'h80 | 8'(h));
            trial(1'b0, 16'h0, 16'h0, 16'h0, 1'b1, 3);
            band(1'b0, 16'(128 + h * 2048), 16'(129 + h * 2048));
        end
        // Sum mode against per-axis mode
        host.wr(LHG_ADDR_HYS_MODE, 8'h85);
        trial(1'b0, 16'd60, 16'hffc4, 16'h0, 1'b1, 3);
        trial(1'b0, 16'd60, 16'hffc4, 16'd10, 1'b0, 3);
        host.wr(LHG_ADDR_HYS_MODE, 8'h81);
        trial(1'b0, 16'd60, 16'hffc4, 16'd60, 1'b1, 3);
        // High threshold per range, zero field and a nonzero field
        host.wr(LHG_ADDR_HIGH_DUR, 8'h01);
        for (int r = 0; r < 4; r++) begin
            range = 2'(r);
            for (int t = 0; t < 3; t += 2) begin
                host.wr(LHG_ADDR_HIGH_TH, 8'(t));
                trial(1'b1, t ? 16'(t * 128 + 1) : 16'd65, 16'h0, 16'h0, 1'b1, 1);
                trial(1'b1, t ? 16'(t * 128) : 16'd64, 16'h0, 16'h0, 1'b0, 1);
            end
            // Hysteresis scales with range just as the samples do
            host.wr(LHG_ADDR_HIGH_TH, 8'h20);
            host.wr(LHG_ADDR_HYS_MODE, 8'h41);
            trial(1'b1, 16'd4097, 16'h0, 16'h0, 1'b1, 1);
            band(1'b1, 16'd2049, 16'd2048);
        end
        host.wr(LHG_ADDR_HIGH_DUR, 8'h00);
        trial(1'b1, 16'd4097, 16'h0, 16'h0, 1'b1, 0);
        finish_test();
    end
endmodule
`default_nettype wire
